// file: common/ilo_pkg.sv
/*
  constants, types and field layout for the indexed literal offset
  operand decoder: opcode patterns, field positions, address widths,
  the four-phase cycle and the status flag bundle.
  assumes an 8-bit data path and a 12-bit data memory address.
*/
// Notes on behaviour
// - extended mode: small file operand offsets pointer two
// - offset only when access bit is zero
// - config bit low disables indexed addressing
// - add form adds working register to indexed byte
// - destination bit picks working register or byte
// - add updates negative, overflow, carry, digit-carry, zero
// - bit set form sets chosen bit, flags untouched
// - set-all form writes all ones, flags untouched
// - one word, one four-phase instruction cycle
package ilo_pkg;

  // data memory geometry
  localparam int unsigned ADDR_W = 12;  // data address width
  localparam int unsigned DATA_W = 8;   // data byte width

  // addressing limits and bases
  localparam logic [7:0]        INDEX_LIMIT = 8'h5F;  // top offset value
  localparam logic [3:0]        ACCESS_HI   = 4'hF;   // high access half
  localparam logic [3:0]        ACCESS_LO   = 4'h0;   // low access half
  localparam logic [DATA_W-1:0] ALL_ONES    = 8'hFF;  // set-all value
  localparam logic [DATA_W-1:0] ZERO_BYTE   = 8'h00;  // cleared byte

  // opcode patterns, compared against the upper instruction bits
  localparam logic [5:0] ADD_OPC    = 6'h09;  // 0010 01xx
  localparam logic [3:0] BITSET_OPC = 4'h8;   // 1000 xxxx
  localparam logic [6:0] SETALL_OPC = 7'h34;  // 0110 100x

  // field positions inside the 16-bit program word
  localparam int unsigned ACC_BIT  = 8;   // access bank select bit
  localparam int unsigned DEST_BIT = 9;   // destination select bit
  localparam int unsigned BSEL_LSB = 9;   // bit number field, 3 wide
  localparam int unsigned NIB_MSB  = 3;   // top bit of the low nibble
  localparam int unsigned NIB_CARRY  = 4;   // carry bit of nibble sum
  localparam int unsigned WORD_MSB   = 15;  // top bit of the word
  localparam int unsigned ADD_LSB    = 10;  // low bit of add opcode
  localparam int unsigned BITSET_LSB = 12;  // low bit of bit set opcode
  localparam int unsigned SETALL_LSB = 9;   // low bit of set-all opcode
  localparam int unsigned FLD_MSB    = 7;   // top bit of file field

  // the four phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } ilo_phase_t;

  // decoded operation
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ADD  = 2'b01,
    OP_BITSET = 2'b10,
    OP_SETALL = 2'b11
  } ilo_op_t;

  // one decoded instruction
  typedef struct packed {
    ilo_op_t           op;         // operation
    logic              dest_file;  // 1: result to data byte
    logic [2:0]        bit_sel;    // bit number for bit set
    logic              indexed;    // pointer-relative address used
    logic [ADDR_W-1:0] addr;       // effective data address
  } ilo_dec_t;

  // status flags in the core's bit order
  typedef struct packed {
    logic neg;    // result bit 7
    logic ovf;    // signed overflow
    logic zero;   // result is zero
    logic dcarry; // carry out of the low nibble
    logic carry;  // carry out of bit 7
  } ilo_status_t;

endpackage : ilo_pkg

// file: rtl/ilo_phase.sv
/*
  four-phase sequencer: walks decode, read, process, write once per
  instruction cycle, one phase per core clock.
  assumes a synchronous active-high reset that restarts at decode.
*/
`timescale 1ns/1ps
module ilo_phase (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // current phase
  output ilo_pkg::ilo_phase_t    phase
);

  ilo_pkg::ilo_phase_t phase_reg;   // current phase
  ilo_pkg::ilo_phase_t phase_next;  // phase for the next clock

  // the phase always advances; the count wraps from write to decode
  always_comb begin
    phase_next = ilo_pkg::ilo_phase_t'(phase_reg + 2'b01);
  end

  // register the phase
  always_ff @(posedge core_clk) begin
    if (reset) begin
      phase_reg <= ilo_pkg::PH_DECODE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;

endmodule : ilo_phase

// file: rtl/ilo_decode.sv
/*
  decode and operand logic for the indexed add, bit set and set-all
  instructions. one instruction is taken in the decode phase, its byte
  read in the read phase, the result formed in the process phase and
  written out in the write phase.
  assumes data memory answers a read address in the same clock, and
  that the core holds pointer two, the working register and the bank
  select steady for the whole instruction cycle.
*/
`timescale 1ns/1ps
module ilo_decode (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  // configuration
  input  wire logic                         extended_set_config_bit,
  // instruction fetch
  input  wire logic                         instr_valid,
  input  wire logic [15:0]                  instr_word,
  output logic                              instr_ready,
  // core registers
  input  wire logic [ilo_pkg::ADDR_W-1:0]   indirect_pointer_two,
  input  wire logic [3:0]                   bank_select,
  input  wire logic [ilo_pkg::DATA_W-1:0]   working_register,
  // data memory read port
  output logic [ilo_pkg::ADDR_W-1:0]        mem_rd_addr,
  input  wire logic [ilo_pkg::DATA_W-1:0]   mem_rd_data,
  // data memory write port
  output logic                              mem_wr_en,
  output logic [ilo_pkg::ADDR_W-1:0]        mem_wr_addr,
  output logic [ilo_pkg::DATA_W-1:0]        mem_wr_data,
  // working register write
  output logic                              w_wr_en,
  output logic [ilo_pkg::DATA_W-1:0]        w_wr_data,
  // status write
  output logic                              status_wr_en,
  output ilo_pkg::ilo_status_t              status_out
);

  ilo_pkg::ilo_phase_t phase;  // current phase of the cycle

  // phase sequencer
  ilo_phase i_ilo_phase (
    .core_clk (core_clk),
    .reset    (reset),
    .phase    (phase)
  );

  // a new word is accepted only at the decode phase
  assign instr_ready = (phase == ilo_pkg::PH_DECODE);

  wire logic taken = instr_ready && instr_valid;  // word accepted

  // decode group
  ilo_pkg::ilo_dec_t dec_reg;   // instruction in flight
  ilo_pkg::ilo_dec_t dec_next;
  logic [7:0]        fld;       // file operand field
  logic              acc_a;     // access bank bit

  // decode: operation, fields and effective address
  always_comb begin
    dec_next = dec_reg;
    fld      = instr_word[ilo_pkg::FLD_MSB:0];
    acc_a    = instr_word[ilo_pkg::ACC_BIT];
    if (taken) begin
      dec_next.op        = ilo_pkg::OP_NONE;
      dec_next.dest_file = instr_word[ilo_pkg::DEST_BIT];
      dec_next.bit_sel   = instr_word[ilo_pkg::BSEL_LSB +: 3];
      if (instr_word[ilo_pkg::WORD_MSB:ilo_pkg::ADD_LSB]
          == ilo_pkg::ADD_OPC) begin
        dec_next.op = ilo_pkg::OP_ADD;
      end else if (instr_word[ilo_pkg::WORD_MSB:ilo_pkg::BITSET_LSB]
                   == ilo_pkg::BITSET_OPC) begin
        dec_next.op = ilo_pkg::OP_BITSET;
      end else if (instr_word[ilo_pkg::WORD_MSB:ilo_pkg::SETALL_LSB]
                   == ilo_pkg::SETALL_OPC) begin
        dec_next.op = ilo_pkg::OP_SETALL;
      end
      dec_next.indexed = extended_set_config_bit && !acc_a
                         && (fld <= ilo_pkg::INDEX_LIMIT);
      if (dec_next.indexed) begin
        // zero-extend the offset, keep the low address bits
        dec_next.addr = ilo_pkg::ADDR_W'(indirect_pointer_two
                        + {4'h0, fld});
      end else if (acc_a) begin
        // banked access through the bank select register
        dec_next.addr = {bank_select, fld};
      end else if (fld <= ilo_pkg::INDEX_LIMIT) begin
        // low half of the access bank
        dec_next.addr = {ilo_pkg::ACCESS_LO, fld};
      end else begin
        // special function half of the access bank
        dec_next.addr = {ilo_pkg::ACCESS_HI, fld};
      end
    end else if (instr_ready) begin
      // an empty slot must not replay the last writes
      dec_next.op = ilo_pkg::OP_NONE;
    end
  end

  // register the decoded instruction
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  // read address stands from the read phase to the next decode
  assign mem_rd_addr = dec_reg.addr;

  // operand group
  logic [ilo_pkg::DATA_W-1:0] opnd_reg;   // byte read from memory
  logic [ilo_pkg::DATA_W-1:0] opnd_next;
  logic [ilo_pkg::DATA_W-1:0] wval_reg;   // working register copy
  logic [ilo_pkg::DATA_W-1:0] wval_next;

  // capture the operand at the end of the read phase
  always_comb begin
    opnd_next = opnd_reg;
    wval_next = wval_reg;
    if (phase == ilo_pkg::PH_READ) begin
      opnd_next = mem_rd_data;
      wval_next = working_register;
    end
  end

  // register the operands
  always_ff @(posedge core_clk) begin
    if (reset) begin
      opnd_reg <= ilo_pkg::ZERO_BYTE;
      wval_reg <= ilo_pkg::ZERO_BYTE;
    end else begin
      opnd_reg <= opnd_next;
      wval_reg <= wval_next;
    end
  end

  // result group
  logic [ilo_pkg::DATA_W-1:0] res_reg;      // result byte
  logic [ilo_pkg::DATA_W-1:0] res_next;
  logic                       mwe_reg;      // data write strobe
  logic                       mwe_next;
  logic                       wwe_reg;      // working register strobe
  logic                       wwe_next;
  logic                       swe_reg;      // status write strobe
  logic                       swe_next;
  ilo_pkg::ilo_status_t       st_reg;       // flags from the last add
  ilo_pkg::ilo_status_t       st_next;
  logic [ilo_pkg::DATA_W:0]   sum9;         // sum with carry out
  logic [4:0]                 sum_lo;       // low nibble sum
  logic [ilo_pkg::DATA_W-1:0] bit_mask;     // one-hot bit for set

  // process: form the result and the strobes for the write phase
  always_comb begin
    res_next = res_reg;
    st_next  = st_reg;
    mwe_next = 1'b0;
    wwe_next = 1'b0;
    swe_next = 1'b0;
    sum9     = {1'b0, wval_reg} + {1'b0, opnd_reg};
    sum_lo   = {1'b0, wval_reg[ilo_pkg::NIB_MSB:0]}
               + {1'b0, opnd_reg[ilo_pkg::NIB_MSB:0]};
    bit_mask = ilo_pkg::DATA_W'(1) << dec_reg.bit_sel;
    if (phase == ilo_pkg::PH_PROCESS) begin
      unique case (dec_reg.op)
        ilo_pkg::OP_ADD: begin
          res_next       = sum9[ilo_pkg::DATA_W-1:0];
          mwe_next       = dec_reg.dest_file;
          wwe_next       = !dec_reg.dest_file;
          // all five flags follow the sum
          swe_next       = 1'b1;
          st_next.carry  = sum9[ilo_pkg::DATA_W];
          st_next.dcarry = sum_lo[ilo_pkg::NIB_CARRY];
          st_next.zero   = (sum9[ilo_pkg::DATA_W-1:0]
                            == ilo_pkg::ZERO_BYTE);
          st_next.neg    = sum9[ilo_pkg::DATA_W-1];
          st_next.ovf    = (wval_reg[ilo_pkg::DATA_W-1]
                            == opnd_reg[ilo_pkg::DATA_W-1])
                           && (sum9[ilo_pkg::DATA_W-1]
                               != wval_reg[ilo_pkg::DATA_W-1]);
        end
        ilo_pkg::OP_BITSET: begin
          // read-modify-write of one bit, flags kept
          res_next = opnd_reg | bit_mask;
          mwe_next = 1'b1;
        end
        ilo_pkg::OP_SETALL: begin
          // whole byte to ones, flags kept
          res_next = ilo_pkg::ALL_ONES;
          mwe_next = 1'b1;
        end
        ilo_pkg::OP_NONE: begin
          // words outside this decoder leave every strobe low
          res_next = res_reg;
        end
      endcase
    end
  end

  // register the result; strobes last exactly the write phase
  always_ff @(posedge core_clk) begin
    if (reset) begin
      res_reg <= ilo_pkg::ZERO_BYTE;
      st_reg  <= '0;
      mwe_reg <= 1'b0;
      wwe_reg <= 1'b0;
      swe_reg <= 1'b0;
    end else begin
      res_reg <= res_next;
      st_reg  <= st_next;
      mwe_reg <= mwe_next;
      wwe_reg <= wwe_next;
      swe_reg <= swe_next;
    end
  end

  // writes land in the write phase of the same cycle
  assign mem_wr_en    = mwe_reg;
  assign mem_wr_addr  = dec_reg.addr;
  assign mem_wr_data  = res_reg;
  assign w_wr_en      = wwe_reg;
  assign w_wr_data    = res_reg;
  assign status_wr_en = swe_reg;
  assign status_out   = st_reg;

  // checks on the decoder
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence add_taken_s;
    taken && instr_word[ilo_pkg::WORD_MSB:ilo_pkg::ADD_LSB]
             == ilo_pkg::ADD_OPC;
  endsequence

  sequence write_phase_s;
    (phase == ilo_pkg::PH_WRITE) && (mem_wr_en || w_wr_en);
  endsequence

  idx_addr_a: assert property (
    taken && extended_set_config_bit && !instr_word[ilo_pkg::ACC_BIT]
    && instr_word[ilo_pkg::FLD_MSB:0] <= ilo_pkg::INDEX_LIMIT |=>
    dec_reg.indexed && dec_reg.addr == ilo_pkg::ADDR_W'(
    $past(indirect_pointer_two)
    + {4'h0, $past(instr_word[ilo_pkg::FLD_MSB:0])}))
    else $error("indexed address not pointer plus offset");

  acc_bit_a: assert property (
    taken && instr_word[ilo_pkg::ACC_BIT] |=>
    !dec_reg.indexed && dec_reg.addr[ilo_pkg::FLD_MSB:0]
    == $past(instr_word[ilo_pkg::FLD_MSB:0]))
    else $error("access bit set but offset mode used");

  cfg_off_a: assert property (
    taken && !extended_set_config_bit |=> !dec_reg.indexed)
    else $error("offset mode active with extension disabled");

  add_sum_a: assert property (
    add_taken_s |=> ##2 (res_reg == ilo_pkg::DATA_W'(
    $past(wval_reg) + $past(opnd_reg))))
    else $error("add result is not w plus operand");

  add_dest_a: assert property (
    add_taken_s |=> ##2 (mem_wr_en == dec_reg.dest_file)
    && (w_wr_en == !dec_reg.dest_file))
    else $error("add destination select wrong");

  add_flags_a: assert property (
    status_wr_en |-> dec_reg.op == ilo_pkg::OP_ADD
    && status_out.zero == (res_reg == ilo_pkg::ZERO_BYTE)
    && status_out.neg == res_reg[ilo_pkg::DATA_W-1])
    else $error("add flags disagree with sum");

  bit_set_a: assert property (
    mem_wr_en && dec_reg.op == ilo_pkg::OP_BITSET |->
    res_reg[dec_reg.bit_sel] && !status_wr_en
    && (res_reg | (ilo_pkg::DATA_W'(1) << dec_reg.bit_sel))
       == (opnd_reg | (ilo_pkg::DATA_W'(1) << dec_reg.bit_sel)))
    else $error("bit set changed the wrong bits or flags");

  set_all_a: assert property (
    mem_wr_en && dec_reg.op == ilo_pkg::OP_SETALL |->
    mem_wr_data == ilo_pkg::ALL_ONES && !status_wr_en)
    else $error("set-all wrote other than all ones");

  one_cycle_a: assert property (
    add_taken_s |=> ##2 write_phase_s ##1 instr_ready)
    else $error("add did not finish within one instruction cycle");

  idle_slot_a: assert property (
    instr_ready && !instr_valid |=> ##2
    !mem_wr_en && !w_wr_en && !status_wr_en)
    else $error("empty decode slot produced a write");

endmodule : ilo_decode

// file: bench/indexed_offset_operand_decode_bench.sv
/*
  self-checking bench for the indexed literal offset operand decoder:
  add, bit set and set-all through indexed and plain addressing.
  assumes a same-cycle data memory, modelled here by one byte that is
  returned only when the read address is the one expected.
*/
`timescale 1ns/1ps
module indexed_offset_operand_decode_bench;
  // clock and reset
  logic                        core_clk;
  logic                        reset;
  // configuration and fetch
  logic                        extended_set_config_bit;
  logic                        instr_valid;
  logic [15:0]                 instr_word;
  logic                        instr_ready;
  // core registers
  logic [ilo_pkg::ADDR_W-1:0]  indirect_pointer_two;
  logic [3:0]                  bank_select;
  logic [ilo_pkg::DATA_W-1:0]  working_register;
  // memory and write-back
  logic [ilo_pkg::ADDR_W-1:0]  mem_rd_addr;
  logic [ilo_pkg::DATA_W-1:0]  mem_rd_data;
  logic                        mem_wr_en;
  logic [ilo_pkg::ADDR_W-1:0]  mem_wr_addr;
  logic [ilo_pkg::DATA_W-1:0]  mem_wr_data;
  logic                        w_wr_en;
  logic [ilo_pkg::DATA_W-1:0]  w_wr_data;
  logic                        status_wr_en;
  ilo_pkg::ilo_status_t        status_out;
  // bench state
  logic [ilo_pkg::ADDR_W-1:0]  exp_addr;  // address the memory answers
  logic [7:0]                  rd_byte;   // byte held at that address
  int                          num_errors;
  int                          compares;

  ilo_decode i_ilo_decode (
    .core_clk(core_clk), .reset(reset),
    .extended_set_config_bit(extended_set_config_bit),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready),
    .indirect_pointer_two(indirect_pointer_two),
    .bank_select(bank_select), .working_register(working_register),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .w_wr_en(w_wr_en),
    .w_wr_data(w_wr_data), .status_wr_en(status_wr_en),
    .status_out(status_out)
  );

  // a wrong read address sees the inverted byte, so it cannot pass
  assign mem_rd_data = (mem_rd_addr === exp_addr) ? rd_byte : ~rd_byte;

  // 10 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // one comparison, counted
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // single place where the run ends
  task automatic test_done;
    $display("checks %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // one instruction: offer, wait for the take, watch its four phases
  task automatic exec(input logic [15:0] word, input logic cfg,
                      input logic [11:0] ptr, input logic [3:0] bank,
                      input logic [7:0] w, input logic [7:0] rd);
    logic [7:0]           k;
    logic [8:0]           s;
    logic [2:0]           stb;  // {memory, working reg, status}
    logic [7:0]           dat;
    ilo_pkg::ilo_status_t st;
    logic [11:0]          ea;   // expected data address
    int                   n;
    k = word[7:0];
    if (cfg && !word[8] && k <= 8'h5F) begin
      ea = ptr + {4'h0, k};
    end else if (word[8]) begin
      ea = {bank, k};
    end else if (k <= 8'h5F) begin
      ea = {4'h0, k};
    end else begin
      ea = {4'hF, k};
    end
    s = {1'b0, w} + {1'b0, rd};
    st.neg = s[7];
    st.ovf = (w[7] == rd[7]) && (s[7] != w[7]);
    st.zero = (s[7:0] == 8'h00);
    st.dcarry = ({1'b0, w[3:0]} + {1'b0, rd[3:0]}) > 5'h0F;
    st.carry = s[8];
    stb = 3'b000;
    dat = 8'h00;
    if (word[15:10] == 6'b001001) begin
      dat = s[7:0];
      stb = word[9] ? 3'b101 : 3'b011;
    end else if (word[15:12] == 4'h8) begin
      dat = rd | (8'h01 << word[11:9]);
      stb = 3'b100;
    end else if (word[15:9] == 7'b0110100) begin
      dat = 8'hFF;
      stb = 3'b100;
    end
    @(posedge core_clk);
    exp_addr <= ea;
    rd_byte <= rd;
    instr_word <= word;
    instr_valid <= 1'b1;
    extended_set_config_bit <= cfg;
    indirect_pointer_two <= ptr;
    bank_select <= bank;
    working_register <= w;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (!instr_ready && n < 8);
    chk(16'(instr_ready), 16'h0001);
    @(posedge core_clk);
    instr_valid <= 1'b0;
    @(negedge core_clk);
    chk(16'(mem_rd_addr), 16'(exp_addr));
    chk(16'(instr_ready), 16'h0000);
    @(negedge core_clk);
    chk(16'({mem_wr_en, w_wr_en, status_wr_en}), 16'h0000);
    @(negedge core_clk);
    chk(16'({mem_wr_en, w_wr_en, status_wr_en}), 16'(stb));
    if (stb[2]) chk(16'(mem_wr_addr), 16'(exp_addr));
    if (stb[2]) chk(16'(mem_wr_data), 16'(dat));
    if (stb[1]) chk(16'(w_wr_data), 16'(dat));
    if (stb[0]) chk(16'(status_out), 16'(st));
  endtask : exec

  // add with both destinations and flag corner sums
  task automatic test_add;
    exec(16'h242C, 1'b1, 12'hA00, 4'h3, 8'h17, 8'h20);
    exec(16'h262C, 1'b1, 12'hA00, 4'h3, 8'h17, 8'h20);
    exec(16'h2401, 1'b1, 12'h100, 4'h3, 8'h80, 8'h80);
    exec(16'h2602, 1'b1, 12'h100, 4'h3, 8'h0F, 8'h01);
    exec(16'h2403, 1'b1, 12'h100, 4'h3, 8'h7F, 8'h01);
    exec(16'h2404, 1'b1, 12'h100, 4'h3, 8'hFF, 8'h01);
    $display("test add done");
  endtask : test_add

  // every bit number of the bit set form, back to back
  task automatic test_bit_set;
    for (int b = 0; b < 8; b++) begin
      exec(16'h800A | 16'(b << 9), 1'b1, 12'hA00, 4'h3, 8'h55,
           8'h00);
    end
    exec(16'h8E0A, 1'b1, 12'hA00, 4'h3, 8'h00, 8'h55);
    $display("test bit set done");
  endtask : test_bit_set

  // set-all, indexed and plain
  task automatic test_set_all;
    exec(16'h682C, 1'b1, 12'hA00, 4'h3, 8'h00, 8'h00);
    exec(16'h692C, 1'b1, 12'hA00, 4'h5, 8'h00, 8'h12);
    $display("test set all done");
  endtask : test_set_all

  // offset limits, access bit, pointer wrap and config bit off
  task automatic test_addressing;
    exec(16'h685F, 1'b1, 12'h200, 4'h3, 8'h00, 8'h00);
    exec(16'h6860, 1'b1, 12'h200, 4'h3, 8'h00, 8'h00);
    exec(16'h8100, 1'b1, 12'h200, 4'hC, 8'h00, 8'h00);
    exec(16'h685F, 1'b1, 12'hFF0, 4'h3, 8'h00, 8'h00);
    exec(16'h242C, 1'b0, 12'hA00, 4'h3, 8'h01, 8'h02);
    exec(16'h8E5F, 1'b0, 12'hA00, 4'h3, 8'h00, 8'h01);
    $display("test addressing done");
  endtask : test_addressing

  // words outside the three forms are taken and do nothing
  task automatic test_other_words;
    exec(16'h0000, 1'b1, 12'hA00, 4'h3, 8'h11, 8'h22);
    exec(16'hE000, 1'b1, 12'hA00, 4'h3, 8'h11, 8'h22);
    exec(16'h6A2C, 1'b1, 12'hA00, 4'h3, 8'h11, 8'h22);
    $display("test other words done");
  endtask : test_other_words

  // a decode slot with no word offered must write nothing
  task automatic test_idle;
    exec(16'h682C, 1'b1, 12'hA00, 4'h3, 8'h00, 8'h00);
    repeat (4) begin
      @(negedge core_clk);
      chk(16'({mem_wr_en, w_wr_en, status_wr_en}), 16'h0000);
    end
    $display("test idle done");
  endtask : test_idle

  // main sequence: inputs set at time zero, reset held six cycles
  initial begin
    num_errors = 0;
    compares = 0;
    reset = 1'b1;
    extended_set_config_bit = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    indirect_pointer_two = 12'h000;
    bank_select = 4'h0;
    working_register = 8'h00;
    exp_addr = 12'h000;
    rd_byte = 8'h00;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk(16'({mem_wr_en, w_wr_en, status_wr_en}), 16'h0000);
    test_add();
    test_bit_set();
    test_set_all();
    test_addressing();
    test_other_words();
    test_idle();
    test_done();
  end

  // watchdog: about 30 instructions of 4 cycles fit well inside this
  initial begin
    repeat (2000) @(posedge core_clk);
    num_errors++;
    $display("Error at %0t: got %h expected %h", $time, 0, 1);
    test_done();
  end
endmodule : indexed_offset_operand_decode_bench
